// File: rtl/soi_pkg.sv
// Constants and types shared by the transmit overhead inserter.
// Assumes one STS-12 byte stream per instance on a single 125 MHz clock.
package soi_pkg;

   // ************************************************************
   // Frame geometry and fixed byte values
   // ************************************************************
   localparam int ROW_BYTES = 1080;
   localparam int FRAME_ROWS = 9;
   localparam int TOH_BYTES = 36;
   localparam int STS_N = 12;
   localparam int OH_BITS = 288;
   localparam int LAT_CYC = 5;
   localparam logic [7:0] A1_VAL = 8'hF6;
   localparam logic [7:0] A2_VAL = 8'h28;
   localparam logic [6:0] SCR_SEED = 7'h7F;

   // ************************************************************
   // Register offsets, field positions and reset values
   // ************************************************************
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SRC_LO = 8'h01;
   localparam logic [7:0] OFS_SRC_HI = 8'h02;
   localparam logic [7:0] OFS_A1_CORR = 8'h03;
   localparam logic [7:0] OFS_A2_CORR = 8'h04;
   localparam logic [7:0] OFS_CORR_FRAMES = 8'h05;
   localparam logic [7:0] OFS_STATUS = 8'h06;
   localparam logic [7:0] OFS_B1_LAST = 8'h07;
   localparam logic [7:0] OFS_B1_MASK = 8'h0F;
   localparam int CTRL_INSERT = 0;
   localparam int CTRL_NO_A1A2 = 1;
   localparam int CTRL_NO_B1 = 2;
   localparam int CTRL_FERR = 3;
   localparam int CTRL_B1ERR = 4;
   localparam int STAT_CORR = 0;
   localparam int STAT_PAR_ERR = 1;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [14:0] SRC_RST = 15'h0000;
   localparam logic [7:0] CORR_RST = 8'h00;
   localparam logic [7:0] B1_MASK_RST = 8'h00;
   localparam int SEL_K1K2 = 0;
   localparam int SEL_S1M0 = 1;
   localparam int SEL_E1F1E2 = 2;
   localparam int SEL_D1 = 3;

   // ************************************************************
   // Types
   // ************************************************************
   typedef struct packed {
      logic sof;
      logic [7:0] data;
   } soi_beat_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } soi_reg_req_t;

   typedef enum logic [2:0] {
      SRC_PAR = 3'b000,
      SRC_SER = 3'b001,
      SRC_A1 = 3'b010,
      SRC_A2 = 3'b011,
      SRC_B1 = 3'b100,
      SRC_ZERO = 3'b101
   } soi_src_t;

endpackage : soi_pkg

// File: rtl/soi_tx_oh_inserter.sv
// Transmit overhead inserter for one STS-12 stream of a quad slice.
// Assumes parallel input, serial overhead pins and register port are all
// synchronous to clk; a downstream scrambler follows the line output.
//
// Notes on behaviour
// - STS-48 travels as four STS-12 streams; one instance serves one stream.
// - Bytes leave in exactly the order they arrived.
// - Serial overhead data and enable are resampled on clk and taken on rising overhead clock edges.
// - Serial bits fill a 288-bit register, read out as bytes.
// - Software chooses serial insertion or parallel pass-through of overhead.
// - Transparent: all passes except regenerated A1/A2, new B1, eleven zeros.
// - Serial overhead port is ignored in transparent mode.
// - Insert mode: payload passes, overhead comes from the serial port.
// - Insert mode never takes A1/A2 or first B1 from serial.
// - H1, H2, H3 always pass from the parallel input.
// - Fifteen source bits: K1/K2, S1/M0, E1/F1/E2, D1 to D12.
// - A group set to pass-through takes bytes from the parallel input.
// - Options suppress B1 with its zeros, and suppress A1/A2.
// - Serial overhead arrives in frame order, first A1 MSB first.
// - First serial bit is even parity over the previous overhead frame.
// - A1 bytes are F6 and A2 bytes are 28 unless overridden.
// - First A1 leaves five cycles after the frame pulse.
// - Framing error insert sends corrupt values for the programmed frame count, or every frame while the count is zero.
// - Only the last A1 and first A2 are corrupted.
// - B1 is BIP-8 over the previous scrambled frame, inserted unscrambled.
// - With B1 fault enable, mask bits invert the matching BIP-8 bits.
// - A1, A2, J0 and Z0 stay unscrambled downstream.
`timescale 1ns/1ps

module soi_tx_oh_inserter (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Parallel frame input from the fabric.
   input wire logic tx_frame_pulse,
   input wire logic [7:0] tx_data,
   // Serial overhead port.
   input wire logic overhead_serial_clock,
   input wire logic overhead_serial_clock_enable,
   input wire logic overhead_serial_data,
   // Register port.
   input wire soi_pkg::soi_reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   // Line output towards the scrambler.
   output logic line_frame_pulse,
   output logic [7:0] line_data
);
   import soi_pkg::*;

   // ************************************************************
   // Declarations
   // ************************************************************
   logic [7:0] ctrl_r;
   logic [14:0] src_sel_r;
   logic [7:0] a1_corr_r;
   logic [7:0] a2_corr_r;
   logic [7:0] corr_frames_r;
   logic [7:0] b1_mask_r;
   logic par_err_r;
   logic [7:0] rdata_r;
   soi_beat_t in_r;
   logic [10:0] col_r;
   logic [3:0] row_r;
   logic [10:0] col_nxt;
   logic [3:0] row_nxt;
   soi_src_t src;
   logic [7:0] byte_nxt;
   soi_beat_t out_b_r;
   soi_beat_t dly_r [LAT_CYC-2];
   logic ferr_d_r;
   logic [7:0] left_r;
   logic corrupt_act_r;
   logic [6:0] scr_r;
   logic [6:0] scr_cur;
   logic [6:0] scr_nxt;
   logic [7:0] ks;
   logic [7:0] bip_acc_r;
   logic [7:0] b1_prev_r;
   logic ck_s1_r, ck_s2_r, ck_s3_r;
   logic en_s1_r, en_s2_r;
   logic d_s1_r, d_s2_r;
   logic oh_edge;
   logic oh_take;
   logic [OH_BITS-1:0] oh_sh_r;
   logic [OH_BITS-1:0] oh_hold_r;
   logic [8:0] oh_bit_r;
   logic [3:0] oh_row_r;
   logic oh_par_acc_r;
   logic oh_par_bad;
   logic [8:0] hold_idx;

   // ************************************************************
   // Register port
   // ************************************************************

   // Software writes; a stray write to a read-only offset is dropped.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_r <= CTRL_RST;
         src_sel_r <= SRC_RST;
         a1_corr_r <= CORR_RST;
         a2_corr_r <= CORR_RST;
         corr_frames_r <= CORR_RST;
         b1_mask_r <= B1_MASK_RST;
      end else if (reg_req.wr) begin
         case (reg_req.addr)
            OFS_CTRL: ctrl_r <= reg_req.wdata;
            OFS_SRC_LO: src_sel_r[7:0] <= reg_req.wdata;
            OFS_SRC_HI: src_sel_r[14:8] <= reg_req.wdata[6:0];
            OFS_A1_CORR: a1_corr_r <= reg_req.wdata;
            OFS_A2_CORR: a2_corr_r <= reg_req.wdata;
            OFS_CORR_FRAMES: corr_frames_r <= reg_req.wdata;
            OFS_B1_MASK: b1_mask_r <= reg_req.wdata;
            default: ;
         endcase
      end
   end

   // Read data stands one cycle after the strobe; other cycles read zero.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rdata_r <= 8'h00;
      end else if (reg_req.rd) begin
         case (reg_req.addr)
            OFS_CTRL: rdata_r <= ctrl_r;
            OFS_SRC_LO: rdata_r <= src_sel_r[7:0];
            OFS_SRC_HI: rdata_r <= {1'b0, src_sel_r[14:8]};
            OFS_A1_CORR: rdata_r <= a1_corr_r;
            OFS_A2_CORR: rdata_r <= a2_corr_r;
            OFS_CORR_FRAMES: rdata_r <= corr_frames_r;
            OFS_STATUS: rdata_r <= {6'h00, par_err_r, corrupt_act_r};
            OFS_B1_LAST: rdata_r <= b1_prev_r;
            OFS_B1_MASK: rdata_r <= b1_mask_r;
            default: rdata_r <= 8'h00;
         endcase
      end else begin
         rdata_r <= 8'h00;
      end
   end

   assign reg_rdata = rdata_r;

   // Serial parity error is sticky; a write of one clears it, a new error wins.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         par_err_r <= 1'b0;
      end else if (oh_par_bad) begin
         par_err_r <= 1'b1;
      end else if (reg_req.wr && reg_req.addr == OFS_STATUS && reg_req.wdata[STAT_PAR_ERR]) begin
         par_err_r <= 1'b0;
      end
   end

   // ************************************************************
   // Frame position tracking
   // ************************************************************

   // Next position; the pulse marks byte zero of row zero.
   always_comb begin
      col_nxt = (col_r == 11'(ROW_BYTES - 1)) ? 11'h000 : 11'(col_r + 11'h001);
      row_nxt = row_r;
      if (col_r == 11'(ROW_BYTES - 1)) begin
         row_nxt = (row_r == 4'(FRAME_ROWS - 1)) ? 4'h0 : 4'(row_r + 4'h1);
      end
      if (tx_frame_pulse) begin
         col_nxt = 11'h000;
         row_nxt = 4'h0;
      end
   end

   // Input stage holds each byte with its position, in arrival order.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         in_r <= '0;
         col_r <= 11'h000;
         row_r <= 4'h0;
      end else begin
         in_r <= '{sof: tx_frame_pulse, data: tx_data};
         col_r <= col_nxt;
         row_r <= row_nxt;
      end
   end

   // ************************************************************
   // Byte source selection
   // ************************************************************

   // Pick the source of the byte at the input stage.
   always_comb begin
      logic ins;
      logic has_grp;
      int grp;
      int tc;
      ins = ctrl_r[CTRL_INSERT];
      has_grp = 1'b0;
      grp = 0;
      tc = (col_r < 11'd12) ? 0 : ((col_r < 11'd24) ? 1 : 2);
      src = SRC_PAR;
      if (col_r < 11'(TOH_BYTES)) begin
         case (row_r)
            4'h0: begin
               if (tc == 0) begin
                  src = ctrl_r[CTRL_NO_A1A2] ? SRC_PAR : SRC_A1;
               end else if (tc == 1) begin
                  src = ctrl_r[CTRL_NO_A1A2] ? SRC_PAR : SRC_A2;
               end else begin
                  src = ins ? SRC_SER : SRC_PAR;
               end
            end
            4'h1: begin
               if (tc == 0) begin
                  if (ctrl_r[CTRL_NO_B1]) begin
                     src = SRC_PAR;
                  end else begin
                     src = (col_r == 11'd0) ? SRC_B1 : SRC_ZERO;
                  end
               end else begin
                  has_grp = 1'b1;
                  grp = SEL_E1F1E2;
               end
            end
            4'h2: begin
               has_grp = 1'b1;
               grp = SEL_D1 + tc;
            end
            4'h3: src = SRC_PAR;
            4'h4: begin
               if (tc == 0) begin
                  src = ins ? SRC_SER : SRC_PAR;
               end else begin
                  has_grp = 1'b1;
                  grp = SEL_K1K2;
               end
            end
            4'h5, 4'h6, 4'h7: begin
               has_grp = 1'b1;
               grp = SEL_D1 + 3 + 3 * (int'(row_r) - 5) + tc;
            end
            default: begin
               has_grp = 1'b1;
               grp = (tc == 2) ? SEL_E1F1E2 : SEL_S1M0;
            end
         endcase
         if (has_grp) begin
            src = (ins && !src_sel_r[grp]) ? SRC_SER : SRC_PAR;
         end
      end
   end

   assign hold_idx = 9'((TOH_BYTES - 1 - int'(col_r)) * 8);

   // Form the outgoing byte from the chosen source.
   always_comb begin
      case (src)
         SRC_A1: byte_nxt = (corrupt_act_r && col_r == 11'd11) ? a1_corr_r : A1_VAL;
         SRC_A2: byte_nxt = (corrupt_act_r && col_r == 11'd12) ? a2_corr_r : A2_VAL;
         SRC_B1: byte_nxt = b1_prev_r ^ (ctrl_r[CTRL_B1ERR] ? b1_mask_r : 8'h00);
         SRC_ZERO: byte_nxt = 8'h00;
         SRC_SER: byte_nxt = oh_hold_r[hold_idx +: 8];
         default: byte_nxt = in_r.data;
      endcase
   end

   // Output stage plus delay line giving a fixed frame latency.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         out_b_r <= '0;
         for (int i = 0; i < LAT_CYC - 2; i++) begin
            dly_r[i] <= '0;
         end
      end else begin
         out_b_r <= '{sof: in_r.sof, data: byte_nxt};
         dly_r[0] <= out_b_r;
         for (int i = 1; i < LAT_CYC - 2; i++) begin
            dly_r[i] <= dly_r[i-1];
         end
      end
   end

   assign line_frame_pulse = dly_r[LAT_CYC-3].sof;
   assign line_data = dly_r[LAT_CYC-3].data;

   // ************************************************************
   // Framing corruption
   // ************************************************************

   // Arm on the rising enable, then count corrupted frames at each frame start.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ferr_d_r <= 1'b0;
         left_r <= 8'h00;
         corrupt_act_r <= 1'b0;
      end else begin
         ferr_d_r <= ctrl_r[CTRL_FERR];
         if (!ctrl_r[CTRL_FERR]) begin
            corrupt_act_r <= 1'b0;
         end else if (!ferr_d_r) begin
            left_r <= corr_frames_r;
         end else if (in_r.sof) begin
            if (corr_frames_r == 8'h00) begin
               corrupt_act_r <= 1'b1;
            end else if (left_r != 8'h00) begin
               corrupt_act_r <= 1'b1;
               left_r <= left_r - 8'h01;
            end else begin
               corrupt_act_r <= 1'b0;
            end
         end
      end
   end

   // ************************************************************
   // B1 calculation over the scrambled image
   // ************************************************************

   // Model of the downstream scrambler keystream for the current byte.
   always_comb begin
      logic [6:0] s;
      s = (row_r == 4'h0 && col_r == 11'(TOH_BYTES)) ? SCR_SEED : scr_r;
      scr_cur = s;
      for (int b = 7; b >= 0; b--) begin
         ks[b] = s[6];
         s = {s[5:0], s[6] ^ s[5]};
      end
      scr_nxt = s;
      if (row_r == 4'h0 && col_r < 11'(TOH_BYTES)) begin
         ks = 8'h00;
         scr_nxt = scr_cur;
      end
   end

   // Even BIP-8 over the scrambled frame, latched at each frame start.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         scr_r <= SCR_SEED;
         bip_acc_r <= 8'h00;
         b1_prev_r <= 8'h00;
      end else begin
         scr_r <= scr_nxt;
         if (in_r.sof) begin
            b1_prev_r <= bip_acc_r;
            bip_acc_r <= byte_nxt ^ ks;
         end else begin
            bip_acc_r <= bip_acc_r ^ byte_nxt ^ ks;
         end
      end
   end

   // ************************************************************
   // Serial overhead port
   // ************************************************************

   // Resample clock, enable and data; data and enable use the second stage, the clock edge the second and third.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ck_s1_r <= 1'b0;
         ck_s2_r <= 1'b0;
         ck_s3_r <= 1'b0;
         en_s1_r <= 1'b0;
         en_s2_r <= 1'b0;
         d_s1_r <= 1'b0;
         d_s2_r <= 1'b0;
      end else begin
         ck_s1_r <= overhead_serial_clock;
         ck_s2_r <= ck_s1_r;
         ck_s3_r <= ck_s2_r;
         en_s1_r <= overhead_serial_clock_enable;
         en_s2_r <= en_s1_r;
         d_s1_r <= overhead_serial_data;
         d_s2_r <= d_s1_r;
      end
   end

   assign oh_edge = ck_s2_r && !ck_s3_r;
   assign oh_take = oh_edge && en_s2_r && ctrl_r[CTRL_INSERT];
   assign oh_par_bad = oh_take && oh_row_r == 4'h0 && oh_bit_r == 9'h000
                       && d_s2_r != oh_par_acc_r;

   // Shift MSB first; a full row of 36 bytes moves to the readout buffer.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         oh_sh_r <= '0;
         oh_hold_r <= '0;
         oh_bit_r <= 9'h000;
         oh_row_r <= 4'h0;
         oh_par_acc_r <= 1'b0;
      end else if (!ctrl_r[CTRL_INSERT]) begin
         oh_bit_r <= 9'h000;
         oh_row_r <= 4'h0;
         oh_par_acc_r <= 1'b0;
      end else if (oh_take) begin
         oh_sh_r <= {oh_sh_r[OH_BITS-2:0], d_s2_r};
         if (oh_row_r == 4'h0 && oh_bit_r == 9'h000) begin
            oh_par_acc_r <= 1'b0;
         end else begin
            oh_par_acc_r <= oh_par_acc_r ^ d_s2_r;
         end
         if (oh_bit_r == 9'(OH_BITS - 1)) begin
            oh_hold_r <= {oh_sh_r[OH_BITS-2:0], d_s2_r};
            oh_bit_r <= 9'h000;
            oh_row_r <= (oh_row_r == 4'(FRAME_ROWS - 1)) ? 4'h0 : 4'(oh_row_r + 4'h1);
         end else begin
            oh_bit_r <= oh_bit_r + 9'h001;
         end
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************

   frame_latency_a: assert property (@(posedge clk) disable iff (!rst_b)
      tx_frame_pulse |-> ##5 line_frame_pulse)
      else $error("frame pulse not seen at line output after five cycles");

   a1_default_a: assert property (@(posedge clk) disable iff (!rst_b)
      (src == SRC_A1 && !corrupt_act_r) |=> out_b_r.data == 8'hF6)
      else $error("A1 byte not F6");

   a2_corrupt_a: assert property (@(posedge clk) disable iff (!rst_b)
      (src == SRC_A2 && col_r == 11'd12 && corrupt_act_r) |=> out_b_r.data == $past(a2_corr_r))
      else $error("first A2 not corrupted");

   a2_later_a: assert property (@(posedge clk) disable iff (!rst_b)
      (src == SRC_A2 && col_r == 11'd13) |=> out_b_r.data == 8'h28)
      else $error("later A2 byte altered");

   pointer_pass_a: assert property (@(posedge clk) disable iff (!rst_b)
      (row_r == 4'h3 && col_r < 11'd36) |=> out_b_r.data == $past(in_r.data))
      else $error("pointer byte not passed through");

   b1_zeros_a: assert property (@(posedge clk) disable iff (!rst_b)
      (row_r == 4'h1 && col_r > 11'd0 && col_r < 11'd12 && !ctrl_r[CTRL_NO_B1])
      |=> out_b_r.data == 8'h00)
      else $error("bytes after B1 not zero");

   b1_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
      (src == SRC_B1 && ctrl_r[CTRL_B1ERR])
      |=> (out_b_r.data ^ $past(b1_prev_r)) == $past(b1_mask_r))
      else $error("B1 force mask not applied");

   serial_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
      !ctrl_r[CTRL_INSERT] |=> $stable(oh_sh_r))
      else $error("serial register moved in transparent mode");

   parity_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
      oh_par_bad |=> par_err_r)
      else $error("parity error not flagged");

   order_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
      (col_r >= 11'd36) |=> ##3 line_data == $past(in_r.data, 4))
      else $error("payload byte altered or reordered");

endmodule : soi_tx_oh_inserter

// File: bench/soi_fabric_model.sv
// Fabric and serial overhead source model for the overhead inserter bench.
// Assumes clk at 125 MHz; frames run back to back from the release of reset.
`timescale 1ns/1ps
module soi_fabric_model (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Parallel frame stream.
   output logic tx_frame_pulse,
   output logic [7:0] tx_data,
   // Serial overhead port.
   output logic overhead_serial_clock,
   output logic overhead_serial_clock_enable,
   output logic overhead_serial_data,
   // Bench control: starts the serial rows once insert mode is on.
   input wire logic oh_run
);
   logic [13:0] pos_r;
   logic [2:0] div_r;
   logic [8:0] sbit_r;
   logic sen_r;
   logic [7:0] sbyte;

   // Byte position in the 9720-byte frame, wrapping back to the first A1.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pos_r <= 14'h0000;
      end else begin
         pos_r <= (pos_r == 14'h25F7) ? 14'h0000 : pos_r + 14'h0001;
      end
   end

   // Serial clock of eight cycles; enable and bit index change on its falling edge.
   // The first enabled bit is bit zero of a row, so rows line up with the block.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div_r <= 3'h0;
         sbit_r <= 9'h000;
         sen_r <= 1'b0;
      end else begin
         div_r <= div_r + 3'h1;
         if (div_r == 3'h7) begin
            sen_r <= oh_run;
            if (!oh_run || !sen_r) begin
               sbit_r <= 9'h000;
            end else begin
               sbit_r <= (sbit_r == 9'h11F) ? 9'h000 : sbit_r + 9'h001;
            end
         end
      end
   end

   // Pulse lasts one cycle on the first A1; data is a known function of position.
   assign tx_frame_pulse = rst_b & (pos_r == 14'h0000);
   assign tx_data = pos_r[7:0] ^ {2'h0, pos_r[13:8]};
   assign overhead_serial_clock = div_r[2];
   // Each row repeats bytes 0 to 35, each equal to its index; their XOR is zero, so the
   // leading bit of zero is also the correct even parity over the previous frame.
   assign sbyte = {2'h0, sbit_r[8:3]};
   assign overhead_serial_clock_enable = sen_r;
   assign overhead_serial_data = sbyte[3'h7 - sbit_r[2:0]];
endmodule : soi_fabric_model

// File: bench/soi_tx_oh_inserter_bench.sv
// Self-checking bench for the transmit overhead inserter.
// Assumes the fabric model in soi_fabric_model.sv and the package soi_pkg.
`timescale 1ns/1ps
module soi_tx_oh_inserter_bench;
   import soi_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   soi_reg_req_t reg_req = '0;
   logic [7:0] reg_rdata, line_data, tx_data;
   logic line_frame_pulse, tx_frame_pulse, sclk, sen, sdat;
   logic [7:0] cap [0:9719];
   int opos = 9720;
   int nfr = 0;
   int cyc = 0;
   int t0 = 0;
   int lat = 0;
   int fails = 0;
   int n_tests = 0;
   logic oh_run = 1'b0;
   logic [7:0] bip = 8'h00;
   logic [7:0] b1_new = 8'h00;
   logic [7:0] b1_old = 8'h00;
   logic [6:0] scr = 7'h7F;
   logic [14:0] sb;

   // ************************************************************
   // Clock, instances and output capture
   // ************************************************************
   always #4 clk = ~clk;

   soi_fabric_model soi_fabric_model_i (.clk(clk), .rst_b(rst_b),
      .tx_frame_pulse(tx_frame_pulse), .tx_data(tx_data), .overhead_serial_clock(sclk),
      .overhead_serial_clock_enable(sen), .overhead_serial_data(sdat), .oh_run(oh_run));
   soi_tx_oh_inserter soi_tx_oh_inserter_i (.clk(clk), .rst_b(rst_b),
      .tx_frame_pulse(tx_frame_pulse), .tx_data(tx_data), .overhead_serial_clock(sclk),
      .overhead_serial_clock_enable(sen), .overhead_serial_data(sdat), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .line_frame_pulse(line_frame_pulse), .line_data(line_data));

   // Stores each output frame, measures the frame pulse latency and keeps the BIP-8
   // of the line bytes after scrambling for the last two frames.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (tx_frame_pulse) t0 <= cyc;
      if (line_frame_pulse) begin
         lat <= cyc - t0;
         cap[0] <= line_data;
         opos <= 1;
         b1_old <= b1_new;
         b1_new <= bip;
         bip <= line_data;
         scr <= SCR_SEED;
      end else if (opos < 9720) begin
         cap[opos] <= line_data;
         opos <= opos + 1;
         if (opos == 9719) nfr <= nfr + 1;
         bip <= bip ^ line_data ^ ((opos < 36) ? 8'h00 : sb[14:7]);
         if (opos >= 36) scr <= sb[6:0];
      end
   end

   // ************************************************************
   // Shared tasks
   // ************************************************************
   // One byte of the 1 + x^6 + x^7 scrambler: keystream in bits 14:7, next state below.
   function automatic logic [14:0] scr_byte(input logic [6:0] s);
      logic [7:0] k;
      for (int b = 7; b >= 0; b--) begin
         k[b] = s[6];
         s = {s[5:0], s[6] ^ s[5]};
      end
      return {k, s};
   endfunction : scr_byte

   assign sb = scr_byte(scr);

   function automatic logic [7:0] ein(input int p);
      return p[7:0] ^ {2'h0, p[13:8]};
   endfunction : ein

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic pass_span(input int r, input int c0, input int c1);
      for (int c = c0; c <= c1; c++) chk(cap[r * 1080 + c], ein(r * 1080 + c));
   endtask : pass_span

   task automatic val_span(input int r, input int c0, input int c1, input logic [7:0] v);
      for (int c = c0; c <= c1; c++) chk(cap[r * 1080 + c], v);
   endtask : val_span

   task automatic ser_span(input int r, input int c0, input int c1);
      for (int c = c0; c <= c1; c++) chk(cap[r * 1080 + c], 8'(c));
   endtask : ser_span

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      reg_req.wr <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      reg_req.rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : reg_rd

   // Waits until one whole frame has left under the current settings.
   task automatic wait_frame();
      int n;
      n = nfr;
      repeat (20000) begin
         @(posedge clk);
         if (nfr >= n + 2) break;
      end
      #1;
   endtask : wait_frame

   task automatic close_out();
      if (fails == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : close_out

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_regs();
      logic [7:0] d;
      reg_rd(OFS_CTRL, d);
      chk(d, CTRL_RST);
      reg_rd(OFS_B1_MASK, d);
      chk(d, B1_MASK_RST);
      reg_wr(OFS_B1_MASK, 8'h5A);
      reg_rd(OFS_B1_MASK, d);
      chk(d, 8'h5A);
      reg_wr(OFS_SRC_HI, 8'hFF);
      reg_rd(OFS_SRC_HI, d);
      chk(d, 8'h7F);
      reg_rd(8'h20, d);
      chk(d, 8'h00);
   endtask : t_regs

   task automatic t_transparent();
      wait_frame();
      chk(8'(lat), 8'(LAT_CYC));
      val_span(0, 0, 11, A1_VAL);
      val_span(0, 12, 23, A2_VAL);
      val_span(1, 1, 11, 8'h00);
      chk(cap[1080], b1_old);
      pass_span(0, 24, 35);
      pass_span(3, 0, 35);
      pass_span(4, 0, 35);
      pass_span(0, 36, 80);
   endtask : t_transparent

   task automatic t_corrupt();
      logic [7:0] d;
      reg_wr(OFS_A1_CORR, 8'h11);
      reg_wr(OFS_A2_CORR, 8'h22);
      reg_wr(OFS_CORR_FRAMES, 8'h00);
      reg_wr(OFS_CTRL, 8'h08);
      wait_frame();
      val_span(0, 0, 10, A1_VAL);
      val_span(0, 11, 11, 8'h11);
      val_span(0, 12, 12, 8'h22);
      val_span(0, 13, 23, A2_VAL);
      reg_rd(OFS_STATUS, d);
      chk(d & 8'h01, 8'h01);
      reg_wr(OFS_CTRL, 8'h00);
      reg_rd(OFS_STATUS, d);
      chk(d & 8'h01, 8'h00);
   endtask : t_corrupt

   task automatic t_suppress();
      logic [7:0] d;
      reg_wr(OFS_CORR_FRAMES, 8'h01);
      reg_wr(OFS_CTRL, 8'h0E);
      wait_frame();
      pass_span(0, 0, 23);
      pass_span(1, 0, 11);
      reg_rd(OFS_STATUS, d);
      chk(d & 8'h01, 8'h00);
   endtask : t_suppress

   task automatic t_insert();
      logic [7:0] d;
      reg_wr(OFS_SRC_LO, 8'hFF);
      reg_wr(OFS_SRC_HI, 8'h3F);
      reg_wr(OFS_CTRL, 8'h11);
      oh_run <= 1'b1;
      wait_frame();
      val_span(0, 0, 11, A1_VAL);
      val_span(1, 1, 11, 8'h00);
      chk(cap[1080], b1_old ^ 8'h5A);
      ser_span(0, 24, 35);
      ser_span(4, 0, 11);
      ser_span(7, 24, 35);
      pass_span(7, 0, 23);
      reg_rd(OFS_STATUS, d);
      chk(d & 8'h02, 8'h00);
      pass_span(3, 0, 35);
      pass_span(4, 12, 35);
      pass_span(2, 0, 35);
      pass_span(1, 12, 35);
      pass_span(8, 0, 35);
      pass_span(5, 0, 35);
      pass_span(0, 36, 80);
   endtask : t_insert

   // Main sequence after two cycles of reset.
   initial begin
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      t_regs();
      t_transparent();
      t_corrupt();
      t_suppress();
      t_insert();
      close_out();
   end

   // Watchdog sized for eight frames of waiting plus register traffic.
   initial begin
      repeat (95000) @(posedge clk);
      fails++;
      close_out();
   end
endmodule : soi_tx_oh_inserter_bench
